/* File: design/isp_core.sv */
// Purpose: Isolated SPI link with four fast paths and three slow channels each way.
// Assumes: All pins are asynchronous to clk_sys; side power is seen on two pins.
// Notes:   The barrier is modelled as a serial shifter between two halves.
`timescale 1ns/1ns
module isp_core
  import isp_pkg::*;
#(
  parameter bit FILTERED = 1'b1
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Side 1, master facing
  input  wire logic              master_clk_in,
  input  wire logic              master_side_data_in,
  input  wire logic              master_side_select_in_n,
  output logic                   master_side_return_out,
  output logic                   master_side_return_oe,
  input  wire logic [SLOW_N-1:0] slow1_in,
  output logic      [SLOW_N-1:0] slow1_out,
  output logic                   slow1_oe,
  input  wire logic              side1_power_ok,
  // Side 2, slave facing
  output logic                   slave_clk_out,
  output logic                   slave_data_out,
  output logic                   slave_side_select_out_n,
  output logic                   side2_fast_oe,
  input  wire logic              slave_return_in,
  input  wire logic [SLOW_N-1:0] slow2_in,
  output logic      [SLOW_N-1:0] slow2_out,
  output logic                   slow2_oe,
  input  wire logic              side2_power_ok
);

  localparam int unsigned BW = $clog2(BIT_CYC);
  localparam int unsigned NW = $clog2(FRAME_BITS + 1);
  localparam int unsigned RW = $clog2(REFRESH_CYC + 1);
  localparam int unsigned WW = $clog2(WDOG_CYC + 1);
  localparam int ROUND_HI = 130;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [PIN_N-1:0] meta_q;
  logic [PIN_N-1:0] sync_q;
  wire  [PIN_N-1:0] pins = {side2_power_ok, side1_power_ok, slow2_in, slow1_in,
                            master_side_select_in_n, slave_return_in,
                            master_side_data_in, master_clk_in};

  // Two flops on every pin; only the second stage is read below.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= 12'h800 | 12'h400 | 12'h008;
      sync_q <= 12'h800 | 12'h400 | 12'h008;
    end
    else
    begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  wire              pwr1_s  = sync_q[10];
  wire              pwr2_s  = sync_q[11];
  wire [SLOW_N-1:0] slow1_s = sync_q[6:4];
  wire [SLOW_N-1:0] slow2_s = sync_q[9:7];

  // ==========================================================================
  // Fast path filters
  // ==========================================================================
  logic [3:0] filt;

  // Clock, master data and return data are filtered only in the noise-immune
  // grade; without it a sub-cycle glitch may drop its second edge, and the
  // wrong level then stands until the next edge or a refresh.
  // Select is filtered in every grade because slaves act on its edges.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_fast
      isp_glitch #(
        .STABLE (GLITCH_CYC + 1),
        .ENABLE (FILTERED || (gi == 3)),
        .INIT   (gi == 3)
      ) u_filt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (sync_q[gi]),
        .dout    (filt[gi])
      );
    end
  endgenerate

  wire isp_fast_t m_fast = '{sel_n: filt[3], mosi: filt[1], sclk: filt[0]};
  wire            s_ret  = filt[2];

  // ==========================================================================
  // Frame shuttle
  // ==========================================================================
  isp_phase_t      phase_q;
  isp_phase_t      phase_d;
  logic [BW-1:0]   tick_q;
  logic [NW-1:0]   bits_q;
  isp_frame_t      tx_q;
  isp_frame_t      rx_q;
  logic            tx_live_q;
  logic            done12_q;
  logic            done21_q;

  wire tick      = (tick_q == BW'(BIT_CYC - 1));
  wire shifting  = (phase_q == PH_S1_SHIFT) || (phase_q == PH_S2_SHIFT);
  wire last_bit  = shifting && tick && (bits_q == NW'(FRAME_BITS - 1));
  wire load      = (phase_q == PH_S1_LOAD) || (phase_q == PH_S2_LOAD);
  wire load_s1   = (phase_q == PH_S1_LOAD);
  wire send_ok   = load_s1 ? pwr1_s : pwr2_s;
  wire isp_frame_t sample1 = '{slow: slow1_s, fast: m_fast};
  wire isp_frame_t sample2 = '{slow: slow2_s, fast: '{sel_n: 1'b0, mosi: 1'b0, sclk: s_ret}};

  // Side 1 sends, then side 2 answers, then round again.
  always_comb
  begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_S1_LOAD:  phase_d = PH_S1_SHIFT;
      PH_S1_SHIFT: phase_d = last_bit ? PH_S2_LOAD : PH_S1_SHIFT;
      PH_S2_LOAD:  phase_d = PH_S2_SHIFT;
      PH_S2_SHIFT: phase_d = last_bit ? PH_S1_LOAD : PH_S2_SHIFT;
    endcase
  end

  // The bit timer free-runs regardless of input activity, so a slow edge
  // waits up to a full round for its sample.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_q <= PH_S1_LOAD;
      tick_q  <= '0;
      bits_q  <= '0;
    end
    else
    begin
      phase_q <= phase_d;
      tick_q  <= (load || tick) ? '0 : tick_q + BW'(1);
      bits_q  <= load ? '0 : (tick ? bits_q + NW'(1) : bits_q);
    end
  end

  // All inputs of the sending side are caught in one cycle, so edges between
  // samples travel together and close edges are spread by whole rounds; order
  // is lost only inside one sample gap, and pulses shorter than a round may
  // never be seen.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_q      <= '0;
      rx_q      <= '0;
      tx_live_q <= 1'b0;
      done12_q  <= 1'b0;
      done21_q  <= 1'b0;
    end
    else
    begin
      // A dead side sends nothing, which is what the far watchdog sees.
      tx_live_q <= load ? send_ok : tx_live_q;
      if (load)
        tx_q <= load_s1 ? sample1 : sample2;
      else if (shifting && tick)
        tx_q <= {1'b0, tx_q[FRAME_BITS-1:1]};
      if (shifting && tick)
        rx_q <= {tx_q[0], rx_q[FRAME_BITS-1:1]};
      done12_q <= last_bit && (phase_q == PH_S1_SHIFT) && tx_live_q;
      done21_q <= last_bit && (phase_q == PH_S2_SHIFT) && tx_live_q;
    end
  end

  // ==========================================================================
  // Quiet detectors for refresh
  // ==========================================================================
  isp_fast_t     m_prev_q;
  logic          r_prev_q;
  logic [RW-1:0] idle12_q;
  logic [RW-1:0] idle21_q;

  wire m_edge   = (m_fast != m_prev_q);
  wire r_edge   = (s_ret != r_prev_q);
  wire quiet12  = (idle12_q == RW'(REFRESH_CYC));
  wire quiet21  = (idle21_q == RW'(REFRESH_CYC));

  // Frame levels may only repair an output once its input has been quiet
  // long enough that the frame cannot be older than the last edge.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      m_prev_q <= FAST_RST;
      r_prev_q <= 1'b0;
      idle12_q <= '0;
      idle21_q <= '0;
    end
    else
    begin
      m_prev_q <= m_fast;
      r_prev_q <= s_ret;
      idle12_q <= m_edge ? '0 : (quiet12 ? idle12_q : idle12_q + RW'(1));
      idle21_q <= r_edge ? '0 : (quiet21 ? idle21_q : idle21_q + RW'(1));
    end
  end

  // ==========================================================================
  // Fast outputs
  // ==========================================================================
  isp_fast_t s_out_q;
  logic      ret_q;

  // Each edge passes straight on, with no reference to the serial clock, so
  // every clock mode goes through untouched. A received frame only repairs a
  // level that has gone wrong.
  wire isp_fast_t s_out_d = m_edge ? m_fast :
                           ((done12_q && quiet12) ? rx_q.fast : s_out_q);
  wire            ret_d   = r_edge ? s_ret :
                           ((done21_q && quiet21) ? rx_q.fast.sclk : ret_q);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_out_q <= FAST_RST;
      ret_q   <= 1'b0;
    end
    else
    begin
      s_out_q <= s_out_d;
      ret_q   <= ret_d;
    end
  end

  assign slave_clk_out           = s_out_q.sclk;
  assign slave_data_out          = s_out_q.mosi;
  assign slave_side_select_out_n = s_out_q.sel_n;
  assign master_side_return_out  = ret_q;

  // ==========================================================================
  // Slow outputs
  // ==========================================================================
  logic [SLOW_N-1:0] slow1_q;
  logic [SLOW_N-1:0] slow2_q;

  // Each side takes all its slow bits from one frame in one cycle and keeps
  // them until the next frame.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slow1_q <= '0;
      slow2_q <= '0;
    end
    else
    begin
      slow2_q <= done12_q ? rx_q.slow : slow2_q;
      slow1_q <= done21_q ? rx_q.slow : slow1_q;
    end
  end

  assign slow1_out = slow1_q;
  assign slow2_out = slow2_q;

  // ==========================================================================
  // Watchdogs
  // ==========================================================================
  logic [WW-1:0] wd1_q;
  logic [WW-1:0] wd2_q;
  logic          oe1_q;
  logic          oe2_q;

  wire wd1_out = (wd1_q == WW'(WDOG_CYC));
  wire wd2_out = (wd2_q == WW'(WDOG_CYC));

  // A side that hears no frame for the timeout releases its outputs; one good
  // frame brings them back. The return line is otherwise always driven, even
  // with select idle, so it cannot be wired-or with others.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wd1_q <= '0;
      wd2_q <= '0;
      oe1_q <= 1'b1;
      oe2_q <= 1'b1;
    end
    else
    begin
      wd1_q <= done21_q ? '0 : (wd1_out ? wd1_q : wd1_q + WW'(1));
      wd2_q <= done12_q ? '0 : (wd2_out ? wd2_q : wd2_q + WW'(1));
      oe1_q <= !wd1_out;
      oe2_q <= !wd2_out;
    end
  end

  assign master_side_return_oe = oe1_q;
  assign slow1_oe              = oe1_q;
  assign side2_fast_oe         = oe2_q;
  assign slow2_oe              = oe2_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  fast_pass_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(m_fast.sclk) |=> (slave_clk_out == $past(m_fast.sclk)))
    else $error("Serial clock edge did not reach the slave side.");

  sel_filter_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(slave_side_select_out_n) |->
      ($past(sync_q[3], 2) == $past(sync_q[3], 3)))
    else $error("Select output moved on an unsettled input.");

  return_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!wd1_out && !$past(wd1_out)) |-> master_side_return_oe)
    else $error("Return line released while frames arrive.");

  slow_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(slow2_out) |-> $past(done12_q))
    else $error("Slow output changed without a frame.");

  slow_group_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done21_q |=> (slow1_out == $past(rx_q.slow)))
    else $error("Slow outputs not taken together from the frame.");

  dir_alt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (phase_q == PH_S1_SHIFT && last_bit) |=> (phase_q == PH_S2_LOAD) ##1
      (phase_q == PH_S2_SHIFT))
    else $error("Direction did not turn after a frame.");

  round_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done12_q |-> ##[1:ROUND_HI] (phase_q == PH_S1_LOAD))
    else $error("Next sample did not come within one round.");

  sample_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load_s1 |=> (tx_q == $past(sample1)))
    else $error("Frame not built from one sample.");

  watchdog_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wd2_out |=> !slow2_oe && !side2_fast_oe)
    else $error("Watchdog timeout left side 2 driven.");

endmodule

/* File: design/isp_glitch.sv */
// Purpose: Glitch filter for one synchronised fast path.
// Assumes: The input is already in the clk_sys domain.
// Notes:   With ENABLE low the path is a plain wire and adds no latency.
`timescale 1ns/1ns
module isp_glitch
  import isp_pkg::*;
#(
  parameter int unsigned STABLE = 2,
  parameter bit          ENABLE = 1'b1,
  parameter bit          INIT   = 1'b0
)
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Data
  input  wire logic din,
  output logic      dout
);

  localparam int unsigned CW = $clog2(STABLE + 1);

  // ==========================================================================
  // Filter
  // ==========================================================================
  generate
    if (ENABLE)
    begin : g_filt
      logic [CW-1:0] cnt_q;
      logic          lvl_q;
      wire           differs = (din != lvl_q);
      wire           settled = (cnt_q == CW'(STABLE - 1));

      // A new level is taken only after it has held STABLE cycles, so a pulse
      // shorter than that never leaves the filter. The price is that latency.
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          cnt_q <= '0;
          lvl_q <= INIT;
        end
        else
        begin
          cnt_q <= (differs && !settled) ? cnt_q + CW'(1) : '0;
          lvl_q <= (differs && settled) ? din : lvl_q;
        end
      end
      assign dout = lvl_q;
    end
    else
    begin : g_pass
      assign dout = din;
    end
  endgenerate

endmodule

/* File: design/isp_pkg.sv */
// Purpose: Shared constants and types for the isolated SPI block with slow channels.
// Assumes: A 100 MHz system clock; every pin input is asynchronous to it.
// Notes:   Times are kept in their own unit, and cycle counts are derived from them.
package isp_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_NS      = 10;
  // Widest rejected glitch width on a filtered fast path. Rounded up.
  localparam int unsigned GLITCH_NS   = 10;
  localparam int unsigned GLITCH_CYC  = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  // Width of one serial bit across the barrier.
  localparam int unsigned BIT_NS      = 200;
  localparam int unsigned BIT_CYC     = BIT_NS / CLK_NS;
  // A fast input that stays quiet this long is refreshed from the frames. Rounded up.
  localparam int unsigned REFRESH_NS  = 1200;
  localparam int unsigned REFRESH_CYC = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
  // No frame for this long means the far side is dead. Rounded down.
  localparam int unsigned WDOG_NS     = 5000;
  localparam int unsigned WDOG_CYC    = WDOG_NS / CLK_NS;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int unsigned FRAME_BITS  = 6;
  localparam int unsigned SLOW_N      = 3;
  localparam int unsigned PIN_N       = 12;

  // Fast levels of the master side, in frame order.
  typedef struct packed {
    logic sel_n;
    logic mosi;
    logic sclk;
  } isp_fast_t;

  // One frame: slow levels above the fast levels.
  typedef struct packed {
    logic [SLOW_N-1:0] slow;
    isp_fast_t         fast;
  } isp_frame_t;

  // Shuttle phases, Gray coded along the round trip.
  typedef enum logic [1:0] {
    PH_S1_LOAD  = 2'b00,
    PH_S1_SHIFT = 2'b01,
    PH_S2_LOAD  = 2'b11,
    PH_S2_SHIFT = 2'b10
  } isp_phase_t;

  // Reset levels of the fast outputs: clock and data low, select idle high.
  localparam isp_fast_t FAST_RST = '{sel_n: 1'b1, mosi: 1'b0, sclk: 1'b0};

endpackage

/* File: sim/isp_slave_model.sv */
// Purpose: Behavioural SPI slave on the far side of the isolator.
// Assumes: Data is captured on the rising serial clock; the reply shifts after it.
// Notes:   A released return line shows the inverse of its last level.
`timescale 1ns/1ns
module isp_slave_model
  import isp_pkg::*;
#(
  parameter logic [7:0] REPLY = 8'ha6
)
(
  // Slave pins
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       sel_n,
  output logic            sdo,
  // Observation
  output logic [7:0]      rx_byte
);
  logic [7:0] tx_q;
  logic       sel_q;

  // ====================
  // Shifter
  // ====================
  // One process owns every output, so no line has two drivers. Select low
  // loads the reply so its first bit is ready before any clock edge. A rising
  // clock captures then advances, so any clock polarity gives the same byte.
  // A deselected slave lets go, so the line must not keep its old level.
  initial
  begin
    sdo     = 1'b0;
    rx_byte = 8'h00;
    tx_q    = 8'h00;
    sel_q   = 1'b1;
    forever
    begin
      @(sel_n or posedge sclk);
      if (sel_n !== sel_q)
      begin
        sel_q = sel_n;
        if (sel_n === 1'b0)
        begin
          tx_q = REPLY;
          sdo  = REPLY[7];
        end
        else
          sdo = ~sdo;
      end
      else if (sel_n === 1'b0)
      begin
        rx_byte = {rx_byte[6:0], sdi};
        tx_q    = {tx_q[6:0], 1'b0};
        sdo     = tx_q[7];
      end
    end
  end
endmodule

/* File: sim/test_isp_core.sv */
// Purpose: Self-checking bench for the isolated SPI block.
// Assumes: Noise-immune grade; the link clock runs at 160 ns inside transfers.
// Notes:   Each side's power pin drives one watchdog case.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module test_isp_core;
  import isp_pkg::*;
  localparam logic [7:0] REPLY = 8'ha6;
  logic              clk_sys;
  logic              sys_rst;
  logic              master_clk_in;
  logic              master_side_data_in;
  logic              master_side_select_in_n;
  logic              master_side_return_out;
  logic              master_side_return_oe;
  logic [SLOW_N-1:0] slow1_in;
  logic [SLOW_N-1:0] slow1_out;
  logic              slow1_oe;
  logic              side1_power_ok;
  logic              slave_clk_out;
  logic              slave_data_out;
  logic              slave_side_select_out_n;
  logic              side2_fast_oe;
  logic              slave_return_in;
  logic [SLOW_N-1:0] slow2_in;
  logic [SLOW_N-1:0] slow2_out;
  logic              slow2_oe;
  logic              side2_power_ok;
  logic [7:0]        rx_byte;
  int                mismatches = 0;
  int                num_checks = 0;

  // ====================
  // Instances
  // ====================
  isp_core #(.FILTERED(1'b1)) isp_core_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .master_clk_in(master_clk_in),
    .master_side_data_in(master_side_data_in),
    .master_side_select_in_n(master_side_select_in_n),
    .master_side_return_out(master_side_return_out),
    .master_side_return_oe(master_side_return_oe), .slow1_in(slow1_in),
    .slow1_out(slow1_out), .slow1_oe(slow1_oe), .side1_power_ok(side1_power_ok),
    .slave_clk_out(slave_clk_out), .slave_data_out(slave_data_out),
    .slave_side_select_out_n(slave_side_select_out_n), .side2_fast_oe(side2_fast_oe),
    .slave_return_in(slave_return_in), .slow2_in(slow2_in), .slow2_out(slow2_out),
    .slow2_oe(slow2_oe), .side2_power_ok(side2_power_ok));
  isp_slave_model #(.REPLY(REPLY)) isp_slave_model_inst (
    .sclk(slave_clk_out), .sdi(slave_data_out), .sel_n(slave_side_select_out_n),
    .sdo(slave_return_in), .rx_byte(rx_byte));

  // Free-running system clock.
  always #5 clk_sys = ~clk_sys;

  // ====================
  // Helpers
  // ====================
  // Inputs always move 1 ns after an edge, away from sampling.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Waits for one slow output set; only old, middle or new may ever show.
  task automatic slow_watch(input string nm, input logic d2, input logic [2:0] a,
                            input logic [2:0] b, input logic [2:0] c);
    int         n;
    logic [2:0] s;
    n = 0;
    s = d2 ? slow2_out : slow1_out;
    while (s !== c && n < 400)
    begin
      step(1);
      n++;
      s = d2 ? slow2_out : slow1_out;
      if (s !== a && s !== b && s !== c) `CHK(nm, c, s)
    end
    `CHK(nm, c, s)
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ====================
  // Scenarios
  // ====================
  task automatic t_reset();
    `CHK("sclk rst", 1'b0, slave_clk_out)
    `CHK("sel rst", 1'b1, slave_side_select_out_n)
    `CHK("oe rst", 1'b1, side2_fast_oe)
    `CHK("slow oe rst", 1'b1, slow1_oe)
  endtask

  // One-cycle pulses on select and clock must both be swallowed.
  task automatic t_glitch();
    master_side_select_in_n = 1'b0;
    master_clk_in = 1'b1;
    step(1);
    master_side_select_in_n = 1'b1;
    master_clk_in = 1'b0;
    repeat (12)
    begin
      step(1);
      `CHK("sel glitch", 1'b1, slave_side_select_out_n)
      `CHK("clk glitch", 1'b0, slave_clk_out)
    end
  endtask

  // One byte each way; the return bit is taken just before each rising edge.
  task automatic t_spi(input logic cpol, input logic [7:0] tx);
    master_clk_in = cpol;
    step(16);
    master_side_select_in_n = 1'b0;
    step(16);
    for (int i = 7; i >= 0; i--)
    begin
      master_side_data_in = tx[i];
      master_clk_in = 1'b0;
      step(8);
      `CHK("slave data", tx[i], slave_data_out)
      `CHK("slave clk lo", 1'b0, slave_clk_out)
      `CHK("return bit", REPLY[i], master_side_return_out)
      master_clk_in = 1'b1;
      step(8);
      `CHK("slave clk hi", 1'b1, slave_clk_out)
    end
    master_clk_in = cpol;
    step(8);
    master_side_select_in_n = 1'b1;
    step(16);
    `CHK("slave rx", tx, rx_byte)
    `CHK("return oe", 1'b1, master_side_return_oe)
    `CHK("return idle", slave_return_in, master_side_return_out)
  endtask

  // Both directions, a hold window, then two close edges that may arrive together but never mixed.
  task automatic t_slow();
    slow1_in = 3'b101;
    slow_watch("slow2 out", 1'b1, 3'b000, 3'b000, 3'b101);
    slow2_in = 3'b110;
    slow_watch("slow1 out", 1'b0, 3'b000, 3'b000, 3'b110);
    repeat (300)
    begin
      step(1);
      `CHK("slow hold", 3'b101, slow2_out)
    end
    slow1_in = 3'b111;
    step(30);
    slow1_in = 3'b011;
    slow_watch("slow order", 1'b1, 3'b101, 3'b111, 3'b011);
  endtask

  // Side 1 goes dark; side 2 must let go, then recover on the next frame.
  // Then side 2 goes dark and side 1 must do the same.
  task automatic t_watchdog();
    int n;
    side1_power_ok = 1'b0;
    step(200);
    `CHK("oe early", 1'b1, slow2_oe)
    n = 0;
    while (slow2_oe !== 1'b0 && n < 600)
    begin
      step(1);
      n++;
    end
    `CHK("slow2 oe off", 1'b0, slow2_oe)
    `CHK("fast oe off", 1'b0, side2_fast_oe)
    side1_power_ok = 1'b1;
    n = 0;
    while (slow2_oe !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    `CHK("slow2 oe on", 1'b1, slow2_oe)
    side2_power_ok = 1'b0;
    n = 0;
    while (slow1_oe !== 1'b0 && n < 800)
    begin
      step(1);
      n++;
    end
    `CHK("slow1 oe off", 1'b0, slow1_oe)
    `CHK("return oe off", 1'b0, master_side_return_oe)
    `CHK("slow2 oe kept", 1'b1, slow2_oe)
    side2_power_ok = 1'b1;
    n = 0;
    while (slow1_oe !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    `CHK("slow1 oe on", 1'b1, slow1_oe)
    `CHK("return oe on", 1'b1, master_side_return_oe)
  endtask

  // ====================
  // Main sequence
  // ====================
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    master_clk_in = 1'b0;
    master_side_data_in = 1'b0;
    master_side_select_in_n = 1'b1;
    slow1_in = 3'b000;
    slow2_in = 3'b000;
    side1_power_ok = 1'b1;
    side2_power_ok = 1'b1;
    step(20);
    sys_rst = 1'b0;
    t_reset();
    t_glitch();
    t_spi(1'b0, 8'h5c);
    t_spi(1'b1, 8'h93);
    t_slow();
    t_watchdog();
    end_of_test();
  end

  // Hang guard, well beyond the expected run length.
  initial
  begin
    #300000;
    mismatches++;
    end_of_test();
  end
endmodule
